// ---- shared/csd_pkg.sv ----
// constants shared by the clock source and divider select block
package csd_pkg;

	// register offsets on the plain register port
	localparam logic [7:0] CSD_OFS_MODE   = 8'h00;
	localparam logic [7:0] CSD_OFS_STATUS = 8'h01;

	// clock mode control field positions
	localparam int CSD_BIT_LSO_STOP  = 0;
	localparam int CSD_BIT_HSO_STOP  = 1;
	localparam int CSD_BIT_XTAL_STOP = 2;
	localparam int CSD_SEL_LO        = 4;
	localparam int CSD_SEL_HI        = 5;
	localparam int CSD_DIV_LO        = 6;
	localparam int CSD_DIV_HI        = 7;

	// value after reset: low-speed source, divide by 8, high-speed osc stopped
	localparam logic [7:0] CSD_MODE_RESET = 8'h02;

	// option byte field positions
	localparam int CSD_OPT1_METHOD_LO = 0;
	localparam int CSD_OPT1_METHOD_HI = 1;
	localparam int CSD_OPT2_LSO_STOPPABLE = 4;

	// clock selection codes
	localparam logic [1:0] CSD_SEL_LSO  = 2'h0;
	localparam logic [1:0] CSD_SEL_HSO  = 2'h1;
	localparam logic [1:0] CSD_SEL_XTAL = 2'h2;

	// oscillation method codes
	localparam logic [1:0] CSD_METH_NONE = 2'h0;
	localparam logic [1:0] CSD_METH_MAIN = 2'h1;
	localparam logic [1:0] CSD_METH_SUB  = 2'h2;
	localparam logic [1:0] CSD_METH_EXT  = 2'h3;

	// division codes
	localparam logic [1:0] CSD_DIV8 = 2'h0;
	localparam logic [1:0] CSD_DIV4 = 2'h1;
	localparam logic [1:0] CSD_DIV2 = 2'h2;
	localparam logic [1:0] CSD_DIV1 = 2'h3;

	// source indices of the sampled clock vector
	localparam int CSD_NSRC = 5;
	localparam logic [2:0] CSD_SRC_LSO  = 3'h0;
	localparam logic [2:0] CSD_SRC_HSO  = 3'h1;
	localparam logic [2:0] CSD_SRC_MAIN = 3'h2;
	localparam logic [2:0] CSD_SRC_SUB  = 3'h3;
	localparam logic [2:0] CSD_SRC_EXT  = 3'h4;

	// synchroniser depth ahead of any logic
	localparam int CSD_SYNC_STAGES = 2;

endpackage

// ---- logic/csd_clock_select.sv ----
// clock source selection and divider with clock mode control register
//
// The placing of the registers and the strobed register port were left to the implementer.
`timescale 1ns/10ps
module csd_clock_select
	import csd_pkg::*;
(
	// clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_rstn,
	// register port
	input  wire logic [7:0] i_addr,
	input  wire logic [7:0] i_wdata,
	input  wire logic       i_wr,
	input  wire logic       i_rd,
	output logic      [7:0] o_rdata,
	// factory option bytes and core state
	input  wire logic [7:0] i_option_byte_one,
	input  wire logic [7:0] i_option_byte_two,
	input  wire logic       i_stop_mode,
	// raw oscillator clocks
	input  wire logic       i_lso_clk,
	input  wire logic       i_hso_clk,
	input  wire logic       i_main_crystal_input,
	input  wire logic       i_subclock_crystal_input,
	input  wire logic       i_ext_clk,
	// oscillator run controls
	output logic            o_lso_run,
	output logic            o_hso_run,
	output logic            o_xtal_run,
	// pin function
	output logic            o_crystal_output_pin_port,
	output logic            o_crystal_input_pin_port,
	// generated clocks
	output logic            o_periph_clk,
	output logic            o_cpu_clk
);

	// last count value of each half period, in source rising edges
	function automatic logic [1:0] csd_half_last(input logic [1:0] div);
		case (div)
			CSD_DIV8: csd_half_last = 2'h3;
			CSD_DIV4: csd_half_last = 2'h1;
			default:  csd_half_last = 2'h0;
		endcase
	endfunction

	logic [7:0]          mode;
	logic [1:0]          method;
	logic                lso_stoppable;
	logic                mode_hit;
	logic                stat_hit;
	logic [CSD_NSRC-1:0] src_raw;
	logic [CSD_NSRC-1:0] src_meta;
	logic [CSD_NSRC-1:0] src_sync;
	logic [CSD_NSRC-1:0] src_prev;
	logic [2:0]          want_src;
	logic [2:0]          act_src;
	logic [1:0]          act_div;
	logic [1:0]          div_cnt;
	logic                cpu_q;
	logic                act_level;
	logic                act_rise;
	logic [1:0]          next_sel;
	logic                next_lso_stop;

	assign method        = i_option_byte_one[CSD_OPT1_METHOD_HI:CSD_OPT1_METHOD_LO];
	assign lso_stoppable = i_option_byte_two[CSD_OPT2_LSO_STOPPABLE];
	assign mode_hit      = (i_addr == CSD_OFS_MODE);
	assign stat_hit      = (i_addr == CSD_OFS_STATUS);

	// write filtering of the low-speed stop and selection fields
	always_comb begin
		next_lso_stop = i_wdata[CSD_BIT_LSO_STOP] & lso_stoppable;
		next_sel      = i_wdata[CSD_SEL_HI:CSD_SEL_LO];
		if ((next_sel == CSD_SEL_XTAL) && (method == CSD_METH_NONE)) begin
			next_sel = mode[CSD_SEL_HI:CSD_SEL_LO];
		end
		if (next_sel == 2'h3) begin
			next_sel = mode[CSD_SEL_HI:CSD_SEL_LO];
		end
	end

	// clock mode control register
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			mode <= CSD_MODE_RESET;
		end else if (i_wr && mode_hit) begin
			mode[CSD_DIV_HI:CSD_DIV_LO] <= i_wdata[CSD_DIV_HI:CSD_DIV_LO];
			mode[CSD_SEL_HI:CSD_SEL_LO] <= next_sel;
			mode[3]                     <= 1'b0;
			mode[CSD_BIT_XTAL_STOP]     <= i_wdata[CSD_BIT_XTAL_STOP];
			mode[CSD_BIT_HSO_STOP]      <= i_wdata[CSD_BIT_HSO_STOP];
			mode[CSD_BIT_LSO_STOP]      <= next_lso_stop;
		end
	end

	// read port, data valid in the cycle after the strobe only
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_rdata <= 8'h00;
		end else if (i_rd && mode_hit) begin
			o_rdata <= mode;
		end else if (i_rd && stat_hit) begin
			o_rdata <= {o_xtal_run, o_hso_run, o_lso_run, act_div, act_src};
		end else begin
			o_rdata <= 8'h00;
		end
	end

	// oscillator enables
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_lso_run  <= 1'b0;
			o_hso_run  <= 1'b0;
			o_xtal_run <= 1'b0;
		end else begin
			o_lso_run  <= !lso_stoppable ||
			              (!mode[CSD_BIT_LSO_STOP] && !i_stop_mode);
			o_hso_run  <= !mode[CSD_BIT_HSO_STOP] && !i_stop_mode;
			o_xtal_run <= !mode[CSD_BIT_XTAL_STOP] && !i_stop_mode &&
			              ((method == CSD_METH_MAIN) ||
			               (method == CSD_METH_SUB));
		end
	end

	// pin function from the oscillation method
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_crystal_output_pin_port <= 1'b0;
			o_crystal_input_pin_port  <= 1'b0;
		end else begin
			o_crystal_output_pin_port <= (method == CSD_METH_NONE);
			o_crystal_input_pin_port  <= (method == CSD_METH_NONE) ||
			                             (method == CSD_METH_EXT);
		end
	end

	// oscillator clocks are foreign to i_clk
	assign src_raw = {i_ext_clk, i_subclock_crystal_input, i_main_crystal_input,
	                  i_hso_clk, i_lso_clk};

	for (genvar g = 0; g < CSD_NSRC; g++) begin : g_sync
		always_ff @(posedge i_clk or negedge i_rstn) begin
			if (!i_rstn) begin
				src_meta[g] <= 1'b0;
				src_sync[g] <= 1'b0;
				src_prev[g] <= 1'b0;
			end else begin
				src_meta[g] <= src_raw[g];
				src_sync[g] <= src_meta[g];
				src_prev[g] <= src_sync[g];
			end
		end
	end

	// requested source; unrelated control bits are ignored here
	always_comb begin
		case (mode[CSD_SEL_HI:CSD_SEL_LO])
			CSD_SEL_HSO: want_src = CSD_SRC_HSO;
			CSD_SEL_XTAL: begin
				case (method)
					CSD_METH_MAIN: want_src = CSD_SRC_MAIN;
					CSD_METH_SUB:  want_src = CSD_SRC_SUB;
					CSD_METH_EXT:  want_src = CSD_SRC_EXT;
					default:       want_src = CSD_SRC_LSO;
				endcase
			end
			default: want_src = CSD_SRC_LSO;
		endcase
	end

	assign act_level = src_sync[act_src];
	assign act_rise  = src_sync[act_src] & ~src_prev[act_src];

	// hand over only while both old and new sources sit low
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			act_src <= CSD_SRC_LSO;
		end else if ((want_src != act_src) && !act_level && !src_sync[want_src]) begin
			act_src <= want_src;
		end
	end

	// peripheral clock is the undivided source
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_periph_clk <= 1'b0;
		end else begin
			o_periph_clk <= act_level;
		end
	end

	// divider; a new ratio is taken only where a cpu period begins
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			act_div <= CSD_DIV8;
			div_cnt <= 2'h0;
			cpu_q   <= 1'b0;
		end else if (act_rise) begin
			if ((act_div == CSD_DIV1) ||
			    ((div_cnt == csd_half_last(act_div)) && !cpu_q)) begin
				act_div <= mode[CSD_DIV_HI:CSD_DIV_LO];
				div_cnt <= 2'h0;
				cpu_q   <= 1'b1;
			end else if (div_cnt == csd_half_last(act_div)) begin
				div_cnt <= 2'h0;
				cpu_q   <= ~cpu_q;
			end else begin
				div_cnt <= div_cnt + 2'h1;
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_cpu_clk <= 1'b0;
		end else if (act_div == CSD_DIV1) begin
			o_cpu_clk <= act_level;
		end else begin
			o_cpu_clk <= cpu_q;
		end
	end

	// checks

	chk_lso_stop_set: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(i_wr && mode_hit && i_wdata[CSD_BIT_LSO_STOP] && lso_stoppable)
		|=> mode[CSD_BIT_LSO_STOP] ##1 !o_lso_run)
		else $error("low-speed oscillator stop write not taken");

	chk_lso_stop_block: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(i_wr && mode_hit && !lso_stoppable)
		|=> !mode[CSD_BIT_LSO_STOP])
		else $error("low-speed oscillator stop bit set while stopping disabled");

	chk_lso_in_stop: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(i_rstn && !lso_stoppable && i_stop_mode) |=> o_lso_run)
		else $error("low-speed oscillator stopped although stopping disabled");

	chk_pin_ports: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(i_rstn && (method == CSD_METH_NONE))
		|=> (o_crystal_output_pin_port && o_crystal_input_pin_port))
		else $error("crystal pins not released as ports");

	chk_sel_refuse: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(i_wr && mode_hit && (method == CSD_METH_NONE))
		|=> (mode[CSD_SEL_HI:CSD_SEL_LO] != CSD_SEL_XTAL) &&
		    (mode[CSD_SEL_HI:CSD_SEL_LO] == $past(mode[CSD_SEL_HI:CSD_SEL_LO]) ||
		     $past(i_wdata[CSD_SEL_HI:CSD_SEL_LO]) != CSD_SEL_XTAL))
		else $error("crystal selection accepted with no oscillator pins");

	chk_div_count: assert property (@(posedge i_clk) disable iff (!i_rstn)
		div_cnt <= csd_half_last(act_div))
		else $error("divider count beyond half period");

	chk_reset_state: assert property (@(posedge i_clk)
		$rose(i_rstn) |-> (act_src == CSD_SRC_LSO) && (act_div == CSD_DIV8) &&
		                  mode[CSD_BIT_HSO_STOP])
		else $error("wrong clock state after reset");

	chk_hso_run: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(i_rstn && !mode[CSD_BIT_HSO_STOP] && !i_stop_mode) |=> o_hso_run)
		else $error("high-speed oscillator not started");

	chk_xtal_run: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(i_rstn && !mode[CSD_BIT_XTAL_STOP] && !i_stop_mode && (method == CSD_METH_MAIN))
		|=> o_xtal_run)
		else $error("crystal oscillator not started");

	chk_src_switch: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(act_src != $past(act_src)) |-> !o_periph_clk)
		else $error("source switched while clock high");

	chk_src_map: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(mode[CSD_SEL_HI:CSD_SEL_LO] == CSD_SEL_XTAL && method == CSD_METH_SUB)
		|-> (want_src == CSD_SRC_SUB))
		else $error("32 kHz crystal not requested");

	// reserved selection code leaves the source alone
	chk_sel_code_hold: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(i_rstn && i_wr && mode_hit && (i_wdata[CSD_SEL_HI:CSD_SEL_LO] == 2'h3))
		|=> (mode[CSD_SEL_HI:CSD_SEL_LO] == $past(mode[CSD_SEL_HI:CSD_SEL_LO])))
		else $error("reserved selection code changed the source");

	chk_periph_follow: assert property (@(posedge i_clk) disable iff (!i_rstn)
		i_rstn |=> (o_periph_clk == $past(act_level)))
		else $error("peripheral clock not the undivided source");

	chk_ext_pins: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(i_rstn && (method == CSD_METH_EXT))
		|=> (o_crystal_input_pin_port && !o_crystal_output_pin_port))
		else $error("pin use wrong for external clock");

	chk_sub_run: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(i_rstn && !mode[CSD_BIT_XTAL_STOP] && !i_stop_mode && (method == CSD_METH_SUB))
		|=> o_xtal_run)
		else $error("32 kHz crystal not started");

	// a new ratio only lands on a source rise
	chk_div_at_rise: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(act_div != $past(act_div)) |-> $past(act_rise))
		else $error("division ratio changed between source edges");

	chk_cpu_new_period: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(act_div != $past(act_div)) |-> cpu_q)
		else $error("new ratio did not start a cpu period");

	chk_hso_stop: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(i_rstn && mode[CSD_BIT_HSO_STOP]) |=> !o_hso_run)
		else $error("high-speed oscillator runs while stopped");

	chk_xtal_stop: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(i_rstn && mode[CSD_BIT_XTAL_STOP]) |=> !o_xtal_run)
		else $error("crystal oscillator runs while stopped");

	// handover only while the old source sits low
	chk_src_low_swap: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(act_src != $past(act_src)) |-> !$past(act_level))
		else $error("source handed over while old source high");

	chk_lso_reset_run: assert property (@(posedge i_clk)
		$rose(i_rstn) |=> o_lso_run)
		else $error("low-speed oscillator not running after reset");

	chk_hso_reset_off: assert property (@(posedge i_clk)
		$rose(i_rstn) |=> !o_hso_run)
		else $error("high-speed oscillator running after reset");

endmodule

// ---- testbench/tb_top.sv ----
// self-checking bench for the clock source and divider select block
`timescale 1ns/10ps
module tb_top;
	import csd_pkg::*;
	logic       i_clk;
	logic       i_rstn;
	logic       i_wr;
	logic       i_rd;
	logic       i_stop_mode;
	logic [7:0] i_addr;
	logic [7:0] i_wdata;
	logic [7:0] i_option_byte_one;
	logic [7:0] i_option_byte_two;
	logic [4:0] raw;
	logic [4:0] en;
	logic [7:0] o_rdata;
	logic [7:0] flg;
	logic       o_lso_run, o_hso_run, o_xtal_run, o_out_port, o_in_port;
	logic       o_periph_clk, o_cpu_clk, pp, pc;
	int         fails, cmp_count, cyc, np, nc, npc, pper, prat, tper, hc;
	int         ph [5] = '{0, 0, 0, 0, 0};
	int         half [5] = '{8, 6, 5, 10, 7};
	logic [1:0] meth [5] = '{2'h1, 2'h1, 2'h1, 2'h2, 2'h3};
	logic [7:0] mode [5] = '{8'hC0, 8'h91, 8'h60, 8'h20, 8'hA4};
	int         rat [5] = '{1, 2, 4, 8, 2};

	csd_clock_select i_dut (
		.i_clk                     (i_clk),
		.i_rstn                    (i_rstn),
		.i_addr                    (i_addr),
		.i_wdata                   (i_wdata),
		.i_wr                      (i_wr),
		.i_rd                      (i_rd),
		.o_rdata                   (o_rdata),
		.i_option_byte_one         (i_option_byte_one),
		.i_option_byte_two         (i_option_byte_two),
		.i_stop_mode               (i_stop_mode),
		.i_lso_clk                 (raw[0]),
		.i_hso_clk                 (raw[1]),
		.i_main_crystal_input      (raw[2]),
		.i_subclock_crystal_input  (raw[3]),
		.i_ext_clk                 (raw[4]),
		.o_lso_run                 (o_lso_run),
		.o_hso_run                 (o_hso_run),
		.o_xtal_run                (o_xtal_run),
		.o_crystal_output_pin_port (o_out_port),
		.o_crystal_input_pin_port  (o_in_port),
		.o_periph_clk              (o_periph_clk),
		.o_cpu_clk                 (o_cpu_clk)
	);

	assign en = {1'b1, o_xtal_run, o_xtal_run, o_hso_run, o_lso_run};
	assign flg = {3'h0, o_lso_run, o_hso_run, o_xtal_run, o_out_port, o_in_port};

	initial begin
		i_clk = 1'b0;
		forever #2 i_clk = ~i_clk;
	end

	// oscillators stop only after finishing a high phase
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			report_and_stop();
		end
		for (int k = 0; k < 5; k++) begin
			ph[k] = (ph[k] + 1) % half[k];
			if (ph[k] == 0 && (en[k] || raw[k]))
				raw[k] <= ~raw[k];
		end
	end

	// clock monitor: periods, ratio and high-phase widths
	always @(negedge i_clk) begin
		if (o_periph_clk && !pp) begin
			pper = cyc - tper;
			tper = cyc;
			np++;
		end
		if (o_cpu_clk && !pc) begin
			prat = np - npc;
			npc = np;
			nc++;
		end
		if (pc && !o_cpu_clk && i_rstn && hc < 5)
			chk(8'(hc), 8'h05);
		hc = o_cpu_clk ? hc + 1 : 0;
		pp = o_periph_clk;
		pc = o_cpu_clk;
	end

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask

	task automatic rdc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp);
		@(posedge i_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_clk);
		i_rd <= 1'b0;
		@(negedge i_clk);
		chk(o_rdata & m, exp);
	endtask

	task automatic rst(input logic [1:0] m, input logic s);
		@(posedge i_clk);
		i_rstn <= 1'b0;
		i_option_byte_one <= {6'h00, m};
		i_option_byte_two <= {3'h0, s, 4'h0};
		repeat (12) @(posedge i_clk);
		i_rstn <= 1'b1;
	endtask

	task automatic st;
		repeat (4) @(posedge i_clk);
		@(negedge i_clk);
	endtask

	task automatic wcpu(input int n);
		int t;
		t = nc + n;
		for (int k = 0; k < 2000 && nc < t; k++)
			@(negedge i_clk);
		if (nc < t) begin
			fails++;
			$display("mismatch at %0t: cpu clock stalled", $time);
		end
	endtask

	task automatic report_and_stop;
		$display("comparisons %0d, mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	initial begin
		i_rstn = 1'b0;
		i_wr = 1'b0;
		i_rd = 1'b0;
		i_addr = 8'h00;
		i_wdata = 8'h00;
		i_stop_mode = 1'b0;
		i_option_byte_one = 8'h00;
		i_option_byte_two = 8'h00;
		raw = 5'h00;
		rst(CSD_METH_MAIN, 1'b0);
		st();
		rdc(CSD_OFS_MODE, 8'hFF, CSD_MODE_RESET);
		chk(flg, 8'h14);
		rdc(CSD_OFS_STATUS, 8'h1F, 8'h00);
		wr(CSD_OFS_MODE, 8'h0B);
		rdc(CSD_OFS_MODE, 8'hFF, 8'h02);
		st();
		chk(flg, 8'h14);
		@(posedge i_clk) i_stop_mode <= 1'b1;
		st();
		chk(flg, 8'h10);
		@(posedge i_clk) i_stop_mode <= 1'b0;
		wr(8'h05, 8'hFF);
		rdc(8'h05, 8'hFF, 8'h00);
		rdc(CSD_OFS_MODE, 8'hFF, 8'h02);
		rst(CSD_METH_MAIN, 1'b1);
		wr(CSD_OFS_MODE, 8'h01);
		rdc(CSD_OFS_MODE, 8'hFF, 8'h01);
		st();
		chk(flg, 8'h0C);
		wr(CSD_OFS_MODE, 8'h04);
		st();
		chk(flg, 8'h18);
		wr(CSD_OFS_MODE, 8'h00);
		st();
		chk(flg, 8'h1C);
		for (int m = 0; m < 4; m++) begin
			rst(2'(m), 1'b0);
			st();
			chk(flg & 8'h03, (m == 0) ? 8'h03 : (m == 3) ? 8'h01 : 8'h00);
		end
		rst(CSD_METH_NONE, 1'b0);
		wr(CSD_OFS_MODE, 8'hE0);
		rdc(CSD_OFS_MODE, 8'hFF, 8'hC0);
		wr(CSD_OFS_MODE, 8'h30);
		rdc(CSD_OFS_MODE, 8'hFF, 8'h00);
		for (int e = 0; e < 5; e++) begin
			rst(meth[e], 1'b1);
			wr(CSD_OFS_MODE, 8'h00);
			repeat (40) @(posedge i_clk);
			wr(CSD_OFS_MODE, mode[e]);
			wcpu(3);
			rdc(CSD_OFS_STATUS, 8'h1F, {3'h0, mode[e][7:6], 3'(e)});
			chk(8'(pper), 8'(2 * half[e]));
			chk(8'(prat), 8'(rat[e]));
		end
		report_and_stop();
	end
endmodule
